//--- rtl/dlcc_top.sv
/*
 Dual antenna supply channel control: two control registers over
 AXI4-Lite, tone and switching clock generation, voltage and current
 selection, overload retry and over-temperature shutdown.
 Assumes all pin inputs are asynchronous to ref_clk; the analog stages
 act on the level outputs and report clamp and temperature as levels.
*/
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module dlcc_top
   import dlcc_pkg::*;
#(
   parameter int unsigned T_OFF_CYCLES = dlcc_pkg::T_OFF_CYC,
   parameter int unsigned T_ON_CYCLES  = dlcc_pkg::T_ON_CYC,
   parameter int unsigned SOFT_CYCLES  = dlcc_pkg::SOFT_CYC
)
(
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        nrst,
   // AXI4-Lite write
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [dlcc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   input  wire logic [dlcc_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   output logic [1:0]                       s_axi_bresp,
   // AXI4-Lite read
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   input  wire logic [dlcc_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   output logic [dlcc_pkg::DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   // Supply, temperature and external select
   input  wire logic                        supply_good,
   input  wire logic                        overtemp_ind,
   input  wire logic                        ext_sel_en,
   // Channel pins
   input  wire logic [1:0]                  tone_gate_pin,
   input  wire logic                        force_high_pin_one,
   input  wire logic                        force_high_pin_two,
   input  wire logic [1:0]                  clamp,
   // Stage controls
   output logic                             sw_clk_q,
   output logic [1:0]                       stage_en_q,
   output logic [1:0]                       volt_high_q,
   output logic [1:0]                       cable_boost_q,
   output logic [1:0]                       cur_high_q,
   output logic [1:0]                       tone_q
);

   import dlcc_pkg::*;

   localparam logic [TMR_W-1:0] OFF_M1  = TMR_W'(T_OFF_CYCLES - 1);
   localparam logic [TMR_W-1:0] ON_M1   = TMR_W'(T_ON_CYCLES - 1);
   localparam logic [TMR_W-1:0] SOFT_M1 = TMR_W'(SOFT_CYCLES - 1);
   localparam int               NS      = 9;

   function automatic logic [1:0] reg_hit(input logic [ADDR_W-1:0] a);
      reg_hit = {a[ADDR_W-1:2] == CH2_OFF[ADDR_W-1:2],
                 a[ADDR_W-1:2] == CH1_OFF[ADDR_W-1:2]};
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [NS-1:0] pin_v;
   logic [NS-1:0] meta_q;
   logic [NS-1:0] sync_q;
   logic          sup_s;
   logic          ot_s;
   logic          ext_s;
   logic [1:0]    gate_s;
   logic [1:0]    fhp_s;
   logic [1:0]    clamp_s;

   assign pin_v = {ext_sel_en, clamp, force_high_pin_two, force_high_pin_one,
                   tone_gate_pin, overtemp_ind, supply_good};

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= pin_v;
         sync_q <= meta_q;
      end
   end

   assign sup_s   = sync_q[0];
   assign ot_s    = sync_q[1];
   assign gate_s  = sync_q[3:2];
   assign fhp_s   = sync_q[5:4];
   assign clamp_s = sync_q[7:6];
   assign ext_s   = sync_q[8];

   // ----------------------------------------
   // Soft-start timer
   // ----------------------------------------
   logic [TMR_W-1:0] ss_cnt_q;
   logic             ss_done_q;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ss_cnt_q  <= '0;
         ss_done_q <= 1'b0;
      end
      else if (!sup_s)
      begin
         ss_cnt_q  <= '0;
         ss_done_q <= 1'b0;
      end
      else if (!ss_done_q)
      begin
         if (ss_cnt_q == SOFT_M1)
            ss_done_q <= 1'b1;
         else
            ss_cnt_q <= ss_cnt_q + 1'b1;
      end
   end

   // ----------------------------------------
   // Oscillator and tone divider
   // ----------------------------------------
   logic [SW_W-1:0] sw_cnt_q;
   logic [TN_W-1:0] tn_cnt_q;
   logic            tone_ph_q;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sw_cnt_q  <= '0;
         sw_clk_q  <= 1'b0;
         tn_cnt_q  <= '0;
         tone_ph_q <= 1'b0;
      end
      else if (!sup_s)
      begin
         sw_cnt_q  <= '0;
         sw_clk_q  <= 1'b0;
         tn_cnt_q  <= '0;
         tone_ph_q <= 1'b0;
      end
      else if (sw_cnt_q == SW_HALF_M1)
      begin
         sw_cnt_q <= '0;
         sw_clk_q <= !sw_clk_q;
         if (tn_cnt_q == TN_M1)
         begin
            tn_cnt_q  <= '0;
            tone_ph_q <= !tone_ph_q;
         end
         else
            tn_cnt_q <= tn_cnt_q + 1'b1;
      end
      else
         sw_cnt_q <= sw_cnt_q + 1'b1;
   end

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   logic [ADDR_W-1:0] awa_q;
   logic [7:0]        wd_q;
   logic              ws_q;
   logic              aw_got_q;
   logic              w_got_q;
   logic              wr_go;
   logic [1:0]        wr_hit;

   assign wr_go  = aw_got_q && w_got_q && !s_axi_bvalid;
   assign wr_hit = reg_hit(awa_q);

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awa_q         <= '0;
         wd_q          <= '0;
         ws_q          <= 1'b0;
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awa_q         <= s_axi_awaddr;
            aw_got_q      <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wd_q         <= s_axi_wdata[7:0];
            ws_q         <= s_axi_wstrb[0];
            w_got_q      <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_hit != 2'h0) ? RESP_OKAY : RESP_SLVERR;
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Control registers and temperature flag
   // ----------------------------------------
   logic [7:0] ctrl1_q;
   logic [7:0] ctrl2_q;
   logic       otf_q;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl1_q <= CTRL_RST;
         ctrl2_q <= CTRL_RST;
      end
      else if (!sup_s || ot_s)
      begin
         ctrl1_q <= CTRL_RST;
         ctrl2_q <= CTRL_RST;
      end
      else if (wr_go && ws_q)
      begin
         if (wr_hit[0])
            ctrl1_q <= wd_q & W1_MASK;
         if (wr_hit[1])
            ctrl2_q <= wd_q & W2_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         otf_q <= 1'b0;
      else
         otf_q <= ot_s;
   end

   // ----------------------------------------
   // Channel decode and overload protection
   // ----------------------------------------
   logic [1:0] on_v;
   logic [1:0] vh_v;
   logic [1:0] cb_v;
   logic [1:0] tf_v;
   logic [1:0] cr_v;
   logic [1:0] run_v;
   logic [1:0] ol_off_v;
   logic [1:0] olf_v;
   logic       dyn;

   assign on_v  = {ctrl2_q[B2_ON], ctrl1_q[B1_ON]};
   assign vh_v  = {ctrl2_q[B2_VH], ctrl1_q[B1_VH]};
   assign cb_v  = {ctrl2_q[B2_CB], ctrl1_q[B1_CB]};
   assign tf_v  = {ctrl2_q[B2_TF], ctrl1_q[B1_TF]};
   assign cr_v  = {ctrl2_q[B2_CR], ctrl1_q[B1_CR]};
   assign dyn   = !ctrl1_q[B1_DLO];
   assign run_v = on_v & {2{sup_s && !ot_s && ss_done_q}};

   for (genvar i = 0; i < 2; i++)
   begin : g_ol
      dlcc_overload u_ol (
         .ref_clk (ref_clk),
         .nrst    (nrst),
         .run     (run_v[i]),
         .dyn     (dyn),
         .clamp   (clamp_s[i]),
         .t_off   (OFF_M1),
         .t_on    (ON_M1),
         .off_o   (ol_off_v[i]),
         .flag_q  (olf_v[i])
      );
   end

   // ----------------------------------------
   // Stage outputs
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stage_en_q    <= '0;
         volt_high_q   <= '0;
         cable_boost_q <= '0;
         cur_high_q    <= '0;
         tone_q        <= '0;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            stage_en_q[i]    <= run_v[i] && !ol_off_v[i];
            volt_high_q[i]   <= ext_s ? fhp_s[i] : vh_v[i];
            cable_boost_q[i] <= !ext_s && cb_v[i];
            cur_high_q[i]    <= cr_v[i];
            tone_q[i]        <= run_v[i] && !ol_off_v[i] && tone_ph_q
                                && (tf_v[i] || gate_s[i]);
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   logic [7:0] rd1;
   logic [7:0] rd2;

   assign rd1 = {ctrl1_q[7:1], olf_v[0]};
   assign rd2 = {ctrl2_q[7:2], otf_q, olf_v[1]};

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         case (reg_hit(s_axi_araddr))
            2'h1:
            begin
               s_axi_rdata <= DATA_W'(rd1);
               s_axi_rresp <= RESP_OKAY;
            end
            2'h2:
            begin
               s_axi_rdata <= DATA_W'(rd2);
               s_axi_rresp <= RESP_OKAY;
            end
            default:
            begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   uvlo_hold_a: assert property (!sup_s |=> stage_en_q == 2'h0 && ctrl1_q == CTRL_RST
      && !sw_clk_q)
      else $error("stages not held off under lockout");
   osc_gap_a: assert property ($changed(sw_clk_q) |=> $stable(sw_clk_q) [*8])
      else $error("switching clock toggles too fast");
   tone_div_a: assert property ($past(sup_s) && $changed(tone_ph_q) |-> $changed(sw_clk_q))
      else $error("tone phase not aligned to oscillator");
   tone_gate_a: assert property (!tf_v[0] && !gate_s[0] |=> !tone_q[0])
      else $error("tone present with gate low");
   tone_force_a: assert property (run_v[0] && !ol_off_v[0] && tf_v[0]
      |=> tone_q[0] == $past(tone_ph_q))
      else $error("forced tone not continuous");
   ch_off_a: assert property (!on_v[1] |=> !stage_en_q[1])
      else $error("disabled channel still on");
   voltage_high_bit_a: assert property (!ext_s |=> volt_high_q == $past(vh_v)
      && cable_boost_q == $past(cb_v))
      else $error("voltage select not applied");
   range_a: assert property (1'b1 |=> cur_high_q == $past(cr_v))
      else $error("current range not applied");
   ss_flag_a: assert property (!ss_done_q |-> olf_v == 2'h0)
      else $error("overload flag high before soft-start end");
   ot_off_a: assert property (ot_s |=> stage_en_q == 2'h0 && otf_q
      && ctrl2_q == CTRL_RST)
      else $error("over-temperature did not shut down");
   ot_rel_a: assert property ($fell(ot_s) |=> !otf_q)
      else $error("over-temperature flag not released");
   ext_sel_a: assert property (ext_s |=> volt_high_q == $past(fhp_s)
      && cable_boost_q == 2'h0)
      else $error("external level select ignored");

   ol_retry_c: cover property (ol_off_v[0] ##1 !ol_off_v[0]);
   tone_c: cover property (tone_q[0] && !tf_v[0]);
   ot_c: cover property (ot_s ##1 !ot_s);
   wr_c: cover property (s_axi_bvalid && s_axi_bready);

endmodule

`default_nettype wire

//--- rtl/dlcc_pkg.sv
/*
 Constants, register map and state codes for the dual antenna supply
 channel control block.
 Assumes a 250 MHz reference clock and a 4-bit AXI4-Lite byte address.
*/
package dlcc_pkg;

   // ----------------------------------------
   // Bus and register map
   // ----------------------------------------
   localparam int         ADDR_W      = 4;
   localparam int         DATA_W      = 32;
   localparam logic [3:0] CH1_OFF     = 4'h0;
   localparam logic [3:0] CH2_OFF     = 4'h4;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] CTRL_RST    = 8'h00;
   localparam logic [7:0] W1_MASK     = 8'h7E;
   localparam logic [7:0] W2_MASK     = 8'h7C;

   // Channel one register fields
   localparam int         B1_OLF      = 0;
   localparam int         B1_ON       = 1;
   localparam int         B1_VH       = 2;
   localparam int         B1_CB       = 3;
   localparam int         B1_TF       = 4;
   localparam int         B1_CR       = 5;
   localparam int         B1_DLO      = 6;

   // Channel two register fields
   localparam int         B2_OLF      = 0;
   localparam int         B2_OTF      = 1;
   localparam int         B2_ON       = 2;
   localparam int         B2_VH       = 3;
   localparam int         B2_CB       = 4;
   localparam int         B2_TF       = 5;
   localparam int         B2_CR       = 6;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int         CLK_KHZ     = 250000;
   localparam int         TONE_HZ     = 22000;
   localparam int         OSC_DIV     = 10;
   localparam int         OSC_HZ      = TONE_HZ * OSC_DIV;
   localparam int         SW_HALF_CYC = (CLK_KHZ * 1000) / (2 * OSC_HZ);
   localparam int         SW_W        = 10;
   localparam int         TN_W        = 4;
   localparam logic [SW_W-1:0] SW_HALF_M1 = SW_W'(SW_HALF_CYC - 1);
   localparam logic [TN_W-1:0] TN_M1      = TN_W'(OSC_DIV - 1);
   localparam int         T_OFF_MS    = 900;
   localparam int         T_ON_MS     = 20;
   localparam int         SOFT_US     = 1000;
   localparam int         T_OFF_CYC   = T_OFF_MS * CLK_KHZ;
   localparam int         T_ON_CYC    = T_ON_MS * CLK_KHZ;
   localparam int         SOFT_CYC    = (SOFT_US * CLK_KHZ) / 1000;
   localparam int         TMR_W       = 28;

   // ----------------------------------------
   // Overload protection states
   // ----------------------------------------
   typedef enum logic [2:0] {
      OL_NORM = 3'h1,
      OL_OFF  = 3'h2,
      OL_ON   = 3'h4
   } dlcc_ol_state_t;

endpackage

//--- rtl/dlcc_overload.sv
/*
 Per-channel overload protection: static clamp flag or timed off/on retry.
 Assumes clamp is already synchronised to ref_clk; t_off and t_on are
 interval lengths minus one.
*/
`timescale 1ns/1ps
`default_nettype none

module dlcc_overload
   import dlcc_pkg::*;
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   // Control
   input  wire logic             run,
   input  wire logic             dyn,
   input  wire logic             clamp,
   input  wire logic [TMR_W-1:0] t_off,
   input  wire logic [TMR_W-1:0] t_on,
   // Status
   output wire logic             off_o,
   output logic                  flag_q
);

   dlcc_ol_state_t   state_q;
   logic [TMR_W-1:0] cnt_q;
   logic             seen_q;
   logic             on_end;

   assign off_o  = (state_q == OL_OFF);
   assign on_end = (state_q == OL_ON) && (cnt_q == '0);

   // ----------------------------------------
   // Retry sequencer
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= OL_NORM;
         cnt_q   <= '0;
         seen_q  <= 1'b0;
      end
      else if (!run || !dyn)
      begin
         state_q <= OL_NORM;
         cnt_q   <= '0;
         seen_q  <= 1'b0;
      end
      else
      begin
         case (state_q)
            OL_NORM:
            begin
               if (clamp)
               begin
                  state_q <= OL_OFF;
                  cnt_q   <= t_off;
               end
            end
            OL_OFF:
            begin
               if (cnt_q == '0)
               begin
                  state_q <= OL_ON;
                  cnt_q   <= t_on;
                  seen_q  <= 1'b0;
               end
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            OL_ON:
            begin
               if (clamp)
                  seen_q <= 1'b1;
               if (cnt_q == '0)
               begin
                  if (seen_q || clamp)
                  begin
                     state_q <= OL_OFF;
                     cnt_q   <= t_off;
                  end
                  else
                     state_q <= OL_NORM;
               end
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            default:
               state_q <= OL_NORM;
         endcase
      end
   end

   // ----------------------------------------
   // Overload flag
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         flag_q <= 1'b0;
      else if (!run)
         flag_q <= 1'b0;
      else if (!dyn)
         flag_q <= clamp;
      else if ((state_q == OL_NORM) && clamp)
         flag_q <= 1'b1;
      else if (on_end && !seen_q && !clamp)
         flag_q <= 1'b0;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   ol_trip_a: assert property (run && dyn && state_q == OL_NORM && clamp
      |=> state_q == OL_OFF && flag_q && cnt_q == t_off)
      else $error("overload did not start off interval");
   ol_resume_a: assert property (run && dyn && state_q == OL_OFF && cnt_q == '0
      |=> state_q == OL_ON && cnt_q == t_on)
      else $error("off interval did not end in on interval");
   ol_retry_a: assert property (run && dyn && on_end && (seen_q || clamp)
      |=> state_q == OL_OFF && flag_q)
      else $error("persistent overload did not retry");
   ol_done_a: assert property (run && dyn && on_end && !seen_q && !clamp
      |=> state_q == OL_NORM && !flag_q)
      else $error("clean on interval did not restore normal");
   ol_static_a: assert property (run && !dyn |=> flag_q == $past(clamp))
      else $error("static flag does not follow clamp");

endmodule

`default_nettype wire

//--- sim/dlcc_load_model.sv
/*
 Antenna load model for the channel control block.
 Assumes stage_en comes straight from the block under test.
*/
`timescale 1ns/1ps
`default_nettype none

module dlcc_load_model
(
   // Load control
   input  wire logic [1:0] short_req,
   input  wire logic [1:0] stage_en,
   // Sense
   output wire logic [1:0] clamp
);
   // ----------------
   // Clamp only while powered
   // ----------------
   assign clamp = short_req & stage_en;
endmodule

`default_nettype wire

//--- sim/test_dual_lnb_channel_control.sv
/*
 Register level bench for dlcc_top with short timer values.
 Assumes dlcc_load_model and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module test_dual_lnb_channel_control;
   import dlcc_pkg::*;
   // ----------------
   // Signals
   // ----------------
   logic ref_clk = 0, nrst = 0, supply_good = 1, overtemp_ind = 0;
   logic ext_sel_en = 0, force_high_pin_one = 0, force_high_pin_two = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [1:0] tone_gate_pin = 0, short_req = 0, clamp, s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic sw_clk_q;
   logic [1:0] stage_en_q, volt_high_q, cable_boost_q, cur_high_q, tone_q;
   int num_errors = 0, cmp_count = 0, cyc = 0, n = 0;

   dlcc_top #(.T_OFF_CYCLES(20), .T_ON_CYCLES(10), .SOFT_CYCLES(8)) uut (
      .ref_clk(ref_clk), .nrst(nrst), .supply_good(supply_good), .overtemp_ind(overtemp_ind),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .ext_sel_en(ext_sel_en),
      .tone_gate_pin(tone_gate_pin), .force_high_pin_one(force_high_pin_one),
      .force_high_pin_two(force_high_pin_two), .clamp(clamp), .sw_clk_q(sw_clk_q),
      .stage_en_q(stage_en_q), .volt_high_q(volt_high_q), .cable_boost_q(cable_boost_q),
      .cur_high_q(cur_high_q), .tone_q(tone_q));
   dlcc_load_model load (.short_req(short_req), .stage_en(stage_en_q), .clamp(clamp));

   initial forever #2 ref_clk = ~ref_clk;

   // ----------------
   // Tasks
   // ----------------
   task summarize;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   function automatic logic pick(input int w);
      return w ? tone_q[0] : sw_clk_q;
   endfunction

   // Skip two changes, then count edges to the next one
   task half(input int w, output int cnt);
      logic v;
      cnt = 0;
      repeat (2)
      begin
         v = pick(w);
         while (pick(w) == v) @(posedge ref_clk);
      end
      v = pick(w);
      while (pick(w) == v)
      begin
         @(posedge ref_clk);
         cnt++;
      end
   endtask

   task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge ref_clk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk(32'(s_axi_bresp), 32'(r));
   endtask

   task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge ref_clk);
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      s_axi_araddr <= a;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(s_axi_rdata, e);
      chk(32'(s_axi_rresp), 32'(r));
   endtask

   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         num_errors++;
         summarize;
      end
   end

   // ----------------
   // Sequence
   // ----------------
   initial
   begin
      wt(8);
      nrst <= 1;
      wt(20);
      rd(CH1_OFF, 0, RESP_OKAY);
      rd(CH2_OFF, 0, RESP_OKAY);
      rd(4'h8, 0, RESP_SLVERR);
      wr(4'h8, 32'h0000_00FF, RESP_SLVERR);
      rd(CH1_OFF, 0, RESP_OKAY);
      wr(CH1_OFF, 32'h0000_007E, RESP_OKAY);
      rd(CH1_OFF, 32'h0000_007E, RESP_OKAY);
      wt(10);
      chk({stage_en_q[0], volt_high_q[0], cable_boost_q[0], cur_high_q[0]}, 4'hF);
      short_req <= 2'b01;
      wt(10);
      rd(CH1_OFF, 32'h0000_007F, RESP_OKAY);
      short_req <= 2'b00;
      wt(10);
      rd(CH1_OFF, 32'h0000_007E, RESP_OKAY);
      wr(CH1_OFF, 32'h0000_0002, RESP_OKAY);
      wt(10);
      short_req <= 2'b01;
      wt(6);
      chk(32'(stage_en_q[0]), 0);
      rd(CH1_OFF, 32'h0000_0003, RESP_OKAY);
      wt(18);
      chk(32'(stage_en_q[0]), 1);
      wt(9);
      chk(32'(stage_en_q[0]), 0);
      short_req <= 2'b00;
      wt(80);
      chk(32'(stage_en_q[0]), 1);
      rd(CH1_OFF, 32'h0000_0002, RESP_OKAY);
      {ext_sel_en, force_high_pin_one} <= 2'b11;
      wt(6);
      chk(32'(volt_high_q[0]), 1);
      {ext_sel_en, force_high_pin_one} <= 2'b00;
      wr(CH1_OFF, 32'h0000_0012, RESP_OKAY);
      half(1, n);
      chk(n, SW_HALF_CYC * OSC_DIV);
      half(0, n);
      chk(n, SW_HALF_CYC);
      tone_gate_pin <= 2'b01;
      wr(CH1_OFF, 32'h0000_0002, RESP_OKAY);
      half(1, n);
      chk(n, SW_HALF_CYC * OSC_DIV);
      while (!tone_q[0]) @(posedge ref_clk);
      tone_gate_pin <= 2'b00;
      wt(5);
      chk(32'(tone_q[0]), 0);
      wr(CH2_OFF, 32'h0000_0004, RESP_OKAY);
      overtemp_ind <= 1;
      wt(6);
      chk(32'(stage_en_q), 0);
      rd(CH2_OFF, 32'h0000_0002, RESP_OKAY);
      rd(CH1_OFF, 0, RESP_OKAY);
      overtemp_ind <= 0;
      wt(6);
      rd(CH2_OFF, 0, RESP_OKAY);
      wr(CH1_OFF, 32'h0000_0002, RESP_OKAY);
      wt(20);
      supply_good <= 0;
      wt(6);
      chk(32'(stage_en_q), 0);
      summarize;
   end
endmodule

`default_nettype wire
